// >>> hw/scsm_pkg.sv
// Purpose: Constants, field layouts and types of the system clock source manager.
// Assumes: Registers sit on a 32-bit APB bus, one aligned word each.
// Notes: Every offset and timing count, the control, status and mask bit positions and the control and prescaler reset values live here.
package scsm_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Register byte offsets.
	localparam logic [7:0] SCSM_CTRL_OFF = 8'h00;
	localparam logic [7:0] SCSM_STATUS_OFF = 8'h04;
	localparam logic [7:0] SCSM_MASK_OFF = 8'h08;
	localparam logic [7:0] SCSM_PRESC_OFF = 8'h0C;

	////////////////////////////////////////////////////////////////////////////////
	// Field positions and reset values of the control, status, mask and prescaler registers.
	localparam int SCSM_UNLOCK_BIT = 7;
	localparam int SCSM_RSV_BIT = 6;
	localparam int SCSM_ECIN_BIT = 5;
	localparam int SCSM_CCS_BIT = 4;
	localparam int SCSM_MON_BIT = 3;
	localparam int SCSM_SOD_BIT = 2;
	localparam int SCSM_MODE_LSB = 0;
	localparam int SCSM_FLAG_BIT = 0;
	localparam int SCSM_IRQ_EN_BIT = 0;
	localparam logic [7:0] SCSM_CTRL_RESET = 8'h00;
	localparam logic [7:0] SCSM_UNLOCK_PATTERN = 8'h80;
	localparam logic [6:0] SCSM_PRESC_RESET = 7'h00;

	////////////////////////////////////////////////////////////////////////////////
	// Source mode codes and internal source indices.
	localparam logic [1:0] SCSM_MODE_SLOW = 2'h2;
	localparam logic [1:0] SCSM_MODE_EXT = 2'h3;
	localparam logic [1:0] SCSM_SRC_FAST = 2'h0;
	localparam logic [1:0] SCSM_SRC_SLOW = 2'h1;
	localparam logic [1:0] SCSM_SRC_EXT = 2'h2;

	////////////////////////////////////////////////////////////////////////////////
	// Timing: unlock window in system cycles, failure detection in slow-oscillator ticks.
	localparam logic [2:0] SCSM_UNLOCK_CYCLES = 3'h4;
	localparam int SCSM_SLOW_OSC_HZ = 90000;
	localparam int SCSM_FAIL_DETECT_US = 100;
	localparam int SCSM_MIN_EXT_HZ = 10000;
	localparam logic [3:0] SCSM_FAIL_COUNT =
		4'((SCSM_FAIL_DETECT_US * SCSM_SLOW_OSC_HZ) / 1000000);

	////////////////////////////////////////////////////////////////////////////////
	// Control register layout, bit 7 down to bit 0.
	typedef struct packed {
		logic change_unlock;
		logic reserved;
		logic ext_input_pick;
		logic core_source_select;
		logic monitor_enable;
		logic slow_osc_disable;
		logic [1:0] source_mode_field;
	} scsm_ctrl_s;

	// Oscillator and external clock levels, sampled on the system clock.
	typedef struct packed {
		logic fast_rc_osc;
		logic slow_rc_osc;
		logic ext_clock_in_a;
		logic ext_clock_in_b;
	} scsm_osc_s;

	// Glitch-free switch states.
	typedef enum logic [2:0] {
		SCSM_SW_RUN = 3'b001,
		SCSM_SW_STOP = 3'b010,
		SCSM_SW_START = 3'b100
	} scsm_sw_e;

endpackage

// >>> hw/scsm_top.sv
// Purpose: System clock source manager: protected control, glitch-free switch,
//          7-bit prescaler and external clock failure monitor.
// Assumes: Oscillator and clock pins are sampled as levels on pclk.
// Notes: Function
// Function
// R1 - Unlock is set only by a write of one with all other bits zero.
// R2 - Mode, slow disable, monitor enable, core and input selects change only unlocked.
// R3 - Unlock clears four cycles after setting or on any field write.
// R4 - Rewriting unlock while open neither restarts nor clears the window.
// R5 - Input pick zero routes external input a, one routes input b.
// R6 - Software changes input pick only while core select is zero.
// R7 - Fast oscillator keeps running while core select is zero.
// R8 - Core select zero feeds fast oscillator, one feeds the mode-chosen source.
// R9 - Software leaves source mode alone while core select is one.
// R10 - Failure sets the flag, clears core select, runs from fast oscillator.
// R11 - Monitoring runs only while monitor enable is one.
// R12 - Monitor is active only while the external clock serves the system.
// R13 - Four-bit slow counter, reset by external edges, signals failure at threshold.
// R14 - Detection delay is about 100 us, about 10 kHz minimum.
// R15 - External clock below 10 kHz triggers the failure reaction.
// R16 - Source and speed changes never pass a shortened clock period.
// R17 - Interrupt request is flag and interrupt enable together.
// R18 - A 7-bit prescaler makes system clock and timer tick from every source.
// R19 - Control bits reset to zero; reserved bit 6 reads zero.
// R20 - With core select one, mode 2 is slow, mode 3 external.
// R21 - Software clears core select before changing mode, sets it afterwards.
// R22 - Flag clears on interrupt acknowledge or on writing one.
// R23 - Failure leaves the source mode unchanged.
// R24 - Failure indication is resynchronised before it touches flag or select.
// R25 - Switch stops the old clock low before starting the new one.
//
// Chosen here: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none

module scsm_top (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire scsm_pkg::scsm_osc_s osc_in,
	input wire logic irq_vector_ack,
	output logic fail_irq,
	output logic sys_clk_out,
	output logic timer_prescaled_tick,
	output logic fast_osc_run,
	output logic slow_osc_run
);

	////////////////////////////////////////////////////////////////////////////////
	// Declarations.
	scsm_pkg::scsm_ctrl_s ctrl;
	scsm_pkg::scsm_sw_e sw_state;
	logic [2:0] unlock_cnt;
	logic fail_flag;
	logic irq_en;
	logic [6:0] presc_div;
	logic [6:0] div_act;
	logic [6:0] div_cnt;
	logic [1:0] sel_cur;
	logic [1:0] sel_req;
	logic gate_on;
	logic gated;
	logic clk_q;
	logic clk_rise;
	logic cur_lvl;
	logic ext_level;
	logic ext_q;
	logic slow_q;
	logic ext_rise;
	logic slow_rise;
	logic mon_active;
	logic [3:0] mon_cnt;
	logic mon_trip;
	logic fail_evt;
	logic setup_ph;
	logic wr_acc;
	logic ctrl_sel;
	logic status_sel;
	logic mask_sel;
	logic presc_sel;
	logic mapped;
	logic ctrl_wr;
	logic [7:0] wdata8;
	logic is_unlock_pat;

	// Level of one source by index; reserved codes fall back to the fast oscillator.
	function automatic logic src_lvl(input logic [1:0] idx, input scsm_pkg::scsm_osc_s o,
		input logic ext);
		logic lvl;
		lvl = o.fast_rc_osc;
		case (idx)
			scsm_pkg::SCSM_SRC_SLOW: lvl = o.slow_rc_osc;
			scsm_pkg::SCSM_SRC_EXT: lvl = ext;
			default: lvl = o.fast_rc_osc;
		endcase
		return lvl;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// APB decode. The slave never waits; unmapped addresses answer with an error.
	assign setup_ph = psel & ~penable;
	assign wr_acc = psel & penable & pwrite;
	assign ctrl_sel = (paddr == scsm_pkg::SCSM_CTRL_OFF);
	assign status_sel = (paddr == scsm_pkg::SCSM_STATUS_OFF);
	assign mask_sel = (paddr == scsm_pkg::SCSM_MASK_OFF);
	assign presc_sel = (paddr == scsm_pkg::SCSM_PRESC_OFF);
	assign mapped = ctrl_sel | status_sel | mask_sel | presc_sel;
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~mapped;
	assign ctrl_wr = wr_acc & ctrl_sel;
	assign wdata8 = pwdata[7:0];
	assign is_unlock_pat = (wdata8 == scsm_pkg::SCSM_UNLOCK_PATTERN);

	// Read data is captured in the setup cycle so it is ready in the access cycle.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else if (setup_ph) begin
			prdata <= 32'h00000000;
			if (ctrl_sel) begin
				prdata[7:0] <= ctrl & ~(8'h01 << scsm_pkg::SCSM_RSV_BIT); // [R19]
			end else if (status_sel) begin
				prdata[scsm_pkg::SCSM_FLAG_BIT] <= fail_flag;
			end else if (mask_sel) begin
				prdata[scsm_pkg::SCSM_IRQ_EN_BIT] <= irq_en;
			end else if (presc_sel) begin
				prdata[6:0] <= presc_div;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Protected control register. A failure clears core select last, so it wins.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= scsm_pkg::scsm_ctrl_s'(scsm_pkg::SCSM_CTRL_RESET); // [R19]
		end else begin
			if (ctrl_wr && ctrl.change_unlock && !is_unlock_pat) begin
				ctrl.ext_input_pick <= wdata8[scsm_pkg::SCSM_ECIN_BIT]; // [R2] [R5]
				ctrl.core_source_select <= wdata8[scsm_pkg::SCSM_CCS_BIT]; // [R2]
				ctrl.monitor_enable <= wdata8[scsm_pkg::SCSM_MON_BIT]; // [R2]
				ctrl.slow_osc_disable <= wdata8[scsm_pkg::SCSM_SOD_BIT]; // [R2]
				ctrl.source_mode_field <= wdata8[scsm_pkg::SCSM_MODE_LSB +: 2]; // [R2]
				ctrl.change_unlock <= 1'b0; // [R3]
			end else if (ctrl_wr && !ctrl.change_unlock && is_unlock_pat) begin
				ctrl.change_unlock <= 1'b1; // [R1]
			end else if (ctrl.change_unlock && unlock_cnt == 3'h1) begin
				ctrl.change_unlock <= 1'b0; // [R3]
			end
			if (fail_evt) begin
				ctrl.core_source_select <= 1'b0; // [R10] [R23]
			end
		end
	end

	// Unlock window counter; a rewrite while open is not a reload.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			unlock_cnt <= 3'h0;
		end else if (ctrl_wr && !ctrl.change_unlock && is_unlock_pat) begin
			unlock_cnt <= scsm_pkg::SCSM_UNLOCK_CYCLES; // [R3] [R4]
		end else if (unlock_cnt != 3'h0) begin
			unlock_cnt <= unlock_cnt - 3'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Status flag, interrupt enable and prescaler setting. Set beats clear.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fail_flag <= 1'b0;
		end else if (fail_evt) begin
			fail_flag <= 1'b1; // [R10]
		end else if (irq_vector_ack ||
			(wr_acc && status_sel && pwdata[scsm_pkg::SCSM_FLAG_BIT])) begin
			fail_flag <= 1'b0; // [R22]
		end
	end

	// Interrupt enable and prescaler divider are plain registers.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_en <= 1'b0;
			presc_div <= scsm_pkg::SCSM_PRESC_RESET;
		end else begin
			if (wr_acc && mask_sel) begin
				irq_en <= pwdata[scsm_pkg::SCSM_IRQ_EN_BIT];
			end
			if (wr_acc && presc_sel) begin
				presc_div <= pwdata[6:0];
			end
		end
	end

	// The request is a level that follows the flag and the enable.
	assign fail_irq = fail_flag & irq_en; // [R17]

	////////////////////////////////////////////////////////////////////////////////
	// Source routing: requested source and the live levels of current source.
	assign ext_level = ctrl.ext_input_pick ? osc_in.ext_clock_in_b : osc_in.ext_clock_in_a; // [R5]
	always_comb begin
		sel_req = scsm_pkg::SCSM_SRC_FAST; // [R8]
		if (ctrl.core_source_select) begin
			case (ctrl.source_mode_field)
				scsm_pkg::SCSM_MODE_SLOW: sel_req = scsm_pkg::SCSM_SRC_SLOW; // [R20]
				scsm_pkg::SCSM_MODE_EXT: sel_req = scsm_pkg::SCSM_SRC_EXT; // [R20]
				default: sel_req = scsm_pkg::SCSM_SRC_FAST;
			endcase
		end
	end
	assign cur_lvl = src_lvl(sel_cur, osc_in, ext_level);
	assign gated = gate_on & cur_lvl;

	// Glitch-free switch: park the old source low, then wait for the new one low.
	// A failed clock may be stuck high, so a raised flag lets the stop step pass.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sw_state <= scsm_pkg::SCSM_SW_RUN;
			sel_cur <= scsm_pkg::SCSM_SRC_FAST;
			gate_on <= 1'b1;
		end else begin
			case (sw_state)
				scsm_pkg::SCSM_SW_RUN: begin
					if (sel_req != sel_cur) begin
						sw_state <= scsm_pkg::SCSM_SW_STOP;
					end
				end
				scsm_pkg::SCSM_SW_STOP: begin
					if (!cur_lvl || fail_flag) begin
						gate_on <= 1'b0; // [R25] [R16]
						sel_cur <= sel_req;
						sw_state <= scsm_pkg::SCSM_SW_START;
					end
				end
				scsm_pkg::SCSM_SW_START: begin
					if (!cur_lvl) begin
						gate_on <= 1'b1; // [R25] [R16]
						sw_state <= scsm_pkg::SCSM_SW_RUN;
					end
				end
				default: begin
					sw_state <= scsm_pkg::SCSM_SW_RUN;
					gate_on <= 1'b1;
				end
			endcase
		end
	end

	// Oscillator run requests; the fast one stays on unless another source is live.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fast_osc_run <= 1'b1;
			slow_osc_run <= 1'b1;
		end else begin
			fast_osc_run <= !(ctrl.core_source_select && sw_state == scsm_pkg::SCSM_SW_RUN &&
				sel_cur != scsm_pkg::SCSM_SRC_FAST); // [R7]
			slow_osc_run <= !ctrl.slow_osc_disable;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Prescaler: new divider values load only at a period boundary.
	assign clk_rise = gated & ~clk_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clk_q <= 1'b0;
			div_cnt <= 7'h00;
			div_act <= scsm_pkg::SCSM_PRESC_RESET;
			timer_prescaled_tick <= 1'b0;
			sys_clk_out <= 1'b0;
		end else begin
			clk_q <= gated;
			timer_prescaled_tick <= 1'b0;
			if (clk_rise) begin
				if (div_cnt >= div_act) begin
					div_cnt <= 7'h00;
					div_act <= presc_div; // [R16] [R18]
					timer_prescaled_tick <= 1'b1; // [R18]
					sys_clk_out <= ~sys_clk_out; // [R18]
				end else begin
					div_cnt <= div_cnt + 7'h01;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Failure monitor: slow edges count up, external edges clear the count.
	assign mon_active = ctrl.monitor_enable && ctrl.core_source_select &&
		ctrl.source_mode_field == scsm_pkg::SCSM_MODE_EXT; // [R11] [R12]
	assign ext_rise = ext_level & ~ext_q;
	assign slow_rise = osc_in.slow_rc_osc & ~slow_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_q <= 1'b0;
			slow_q <= 1'b0;
			mon_cnt <= 4'h0;
			mon_trip <= 1'b0;
			fail_evt <= 1'b0;
		end else begin
			ext_q <= ext_level;
			slow_q <= osc_in.slow_rc_osc;
			if (!mon_active || ext_rise) begin
				mon_cnt <= 4'h0; // [R11] [R13]
			end else if (slow_rise && mon_cnt != scsm_pkg::SCSM_FAIL_COUNT) begin
				mon_cnt <= mon_cnt + 4'h1; // [R13]
			end
			mon_trip <= mon_active && !ext_rise && slow_rise &&
				mon_cnt == scsm_pkg::SCSM_FAIL_COUNT - 4'h1; // [R13] [R14] [R15]
			fail_evt <= mon_trip; // [R24]
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Assertions and cover points.
	default clocking scsm_cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	AST_UNLOCK_CLEAN: assert property (ctrl_wr && !ctrl.change_unlock && !is_unlock_pat // [R1]
		|=> !ctrl.change_unlock) else $error("Unlock set by a non-clean write.");
	AST_LOCKED_HOLDS: assert property (ctrl_wr && !ctrl.change_unlock // [R2]
		|=> $stable(ctrl.source_mode_field) && $stable(ctrl.ext_input_pick) &&
		$stable(ctrl.monitor_enable)) else $error("Locked control field changed.");
	AST_UNLOCK_TIMEOUT: assert property ($rose(ctrl.change_unlock) // [R3]
		|-> ##4 !ctrl.change_unlock) else $error("Unlock window not four cycles.");
	AST_UNLOCK_FIELD_CLOSE: assert property (ctrl_wr && ctrl.change_unlock && !is_unlock_pat // [R3]
		|=> !ctrl.change_unlock) else $error("Field write left unlock open.");
	AST_REWRITE_IGNORED: assert property (ctrl.change_unlock && ctrl_wr && is_unlock_pat && // [R4]
		unlock_cnt > 3'h1 |=> ctrl.change_unlock && unlock_cnt == $past(unlock_cnt) - 3'h1)
		else $error("Unlock rewrite disturbed the window.");
	AST_EXT_ROUTE: assert property (sel_cur == scsm_pkg::SCSM_SRC_EXT && gate_on // [R5]
		|-> gated == (ctrl.ext_input_pick ? osc_in.ext_clock_in_b : osc_in.ext_clock_in_a))
		else $error("Wrong external input routed.");
	AST_FAIL_FORCES_FAST: assert property (mon_trip // [R10]
		|=> ##1 !ctrl.core_source_select && fail_flag) else $error("Failure not handled.");
	AST_MON_OFF: assert property (!mon_active |=> mon_cnt == 4'h0 && !mon_trip) // [R11]
		else $error("Monitor ran while disabled.");
	AST_FAIL_THRESHOLD: assert property (mon_trip // [R13]
		|-> $past(mon_cnt) == scsm_pkg::SCSM_FAIL_COUNT - 4'h1 && mon_cnt ==
		scsm_pkg::SCSM_FAIL_COUNT) else $error("Failure tripped off threshold.");
	AST_IRQ_FOLLOWS: assert property ($rose(fail_flag) && irq_en |-> fail_irq) // [R17]
		else $error("Interrupt not raised on flag.");
	AST_START_LOW: assert property ($rose(gate_on) |-> !$past(cur_lvl)) // [R25]
		else $error("New clock enabled while high.");
	AST_FLAG_CLEAR: assert property (fail_flag && irq_vector_ack && !fail_evt // [R22]
		|=> !fail_flag) else $error("Flag not cleared by acknowledge.");
	AST_MODE_KEPT: assert property (fail_evt && !ctrl_wr // [R23]
		|=> $stable(ctrl.source_mode_field)) else $error("Failure changed source mode.");
	AST_RSV_ZERO: assert property (setup_ph && ctrl_sel |=> prdata[6] == 1'b0) // [R19]
		else $error("Reserved control bit read nonzero.");

	COV_UNLOCK_WRITE: cover property ($rose(ctrl.change_unlock) ##[1:3] ctrl_wr);
	COV_FAIL: cover property (fail_evt);
	COV_EXT_RUN: cover property (sw_state == scsm_pkg::SCSM_SW_START &&
		sel_cur == scsm_pkg::SCSM_SRC_EXT ##1 sw_state == scsm_pkg::SCSM_SW_RUN);
	COV_TICK: cover property (timer_prescaled_tick && div_act != 7'h00);

endmodule

`default_nettype wire

// >>> verification/scsm_osc_model.sv
// Purpose: Model of the oscillators and the two external clock sources feeding the manager.
// Assumes: Every source is a level that changes just after a rising pclk edge.
// Notes: A stopped external source holds its pin low, as a broken crystal would.
`timescale 1ns/100ps
`default_nettype none

module scsm_osc_model #(
	parameter int FAST_HALF = 1,
	parameter int SLOW_HALF = 4,
	parameter int EXTA_HALF = 2,
	parameter int EXTB_HALF = 3
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ext_a_stop,
	input wire logic ext_b_stop,
	output scsm_pkg::scsm_osc_s osc
);
	logic [3:0] lv;
	logic [3:0] stop;
	int cnt [4];

	////////////////////////////////////////////////////////////////////////////////
	// Bit order follows the struct: fast, slow, input a, input b.
	assign stop = {2'b00, ext_a_stop, ext_b_stop};
	assign osc = scsm_pkg::scsm_osc_s'(lv);

	// Half period of source i in pclk cycles.
	function automatic int half_of(input int i);
		case (i)
			3: return FAST_HALF;
			2: return SLOW_HALF;
			1: return EXTA_HALF;
			default: return EXTB_HALF;
		endcase
	endfunction

	// Each source toggles after its half period; a stopped one sits low.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lv <= 4'h0;
			for (int i = 0; i < 4; i++) begin
				cnt[i] <= 0;
			end
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (stop[i]) begin
					lv[i] <= 1'b0;
					cnt[i] <= 0;
				end else if (cnt[i] >= half_of(i) - 1) begin
					lv[i] <= ~lv[i];
					cnt[i] <= 0;
				end else begin
					cnt[i] <= cnt[i] + 1;
				end
			end
		end
	end
endmodule

`default_nettype wire

// >>> verification/scsm_top_test.sv
// Purpose: Self-checking bench of the system clock source manager over APB.
// Assumes: Fast period 2, slow 8, input a 4, input b 6 pclk cycles in the model.
// Notes: Prescaler is set to 2, so every tick gap is three source periods.
`timescale 1ns/100ps
`default_nettype none

`define CHECK_EQ(got, exp) \
	begin \
		cmp_count++; \
		if ((got) !== (exp)) begin \
			num_errors++; \
			$display("unexpected at %0t ns: got %0h expected %0h", $time, (got), (exp)); \
		end \
	end

module scsm_top_test;
	localparam logic [7:0] A_CTRL = scsm_pkg::SCSM_CTRL_OFF;
	localparam logic [7:0] A_STAT = scsm_pkg::SCSM_STATUS_OFF;
	localparam logic [7:0] A_MASK = scsm_pkg::SCSM_MASK_OFF;
	localparam logic [7:0] A_PRESC = scsm_pkg::SCSM_PRESC_OFF;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	scsm_pkg::scsm_osc_s osc;
	logic irq_vector_ack, fail_irq, sys_clk_out, tick, fast_osc_run, slow_osc_run;
	logic ext_a_stop, ext_b_stop;
	int num_errors = 0;
	int cmp_count = 0;

	scsm_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .osc_in(osc), .irq_vector_ack(irq_vector_ack), .fail_irq(fail_irq),
		.sys_clk_out(sys_clk_out), .timer_prescaled_tick(tick), .fast_osc_run(fast_osc_run),
		.slow_osc_run(slow_osc_run));
	scsm_osc_model osc_u (.pclk(pclk), .presetn(presetn), .ext_a_stop(ext_a_stop),
		.ext_b_stop(ext_b_stop), .osc(osc));

	////////////////////////////////////////////////////////////////////////////////
	// One APB transfer: setup, then access held until pready is seen high.
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		logic [31:0] d;
		logic e;
		apb(1'b1, a, {24'h000000, v}, d, e);
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		logic e;
		apb(1'b0, a, 32'h00000000, d, e);
		`CHECK_EQ(d, exp)
	endtask

	// Unlock, then write the control value inside the open window.
	task automatic ctrl_set(input logic [7:0] v);
		wr(A_CTRL, scsm_pkg::SCSM_UNLOCK_PATTERN);
		wr(A_CTRL, v);
	endtask

	// Second gap between ticks, so a gap spanning a switch-over is skipped.
	task automatic tick_gap(output int n, output logic tg);
		logic s0;
		do @(posedge pclk); while (tick !== 1'b1);
		repeat (2) begin
			n = 0;
			s0 = sys_clk_out;
			do begin
				@(posedge pclk);
				n++;
			end while (tick !== 1'b1);
		end
		tg = (sys_clk_out !== s0);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset_lock();
		rd_chk(A_CTRL, 32'h00000000);
		`CHECK_EQ(fast_osc_run, 1'b1)
		wr(A_CTRL, 8'h10);
		rd_chk(A_CTRL, 32'h00000000);
		wr(A_CTRL, 8'h90);
		rd_chk(A_CTRL, 32'h00000000);
		wr(A_CTRL, 8'h80);
		rd_chk(A_CTRL, 32'h00000080);
		wr(A_CTRL, 8'h80);
		wr(A_CTRL, 8'h80);
		rd_chk(A_CTRL, 32'h00000000);
		wr(A_CTRL, 8'h04);
		rd_chk(A_CTRL, 32'h00000000);
		ctrl_set(8'h44);
		rd_chk(A_CTRL, 32'h00000004);
		`CHECK_EQ(slow_osc_run, 1'b0)
		ctrl_set(8'h00);
		$display("test reset and lock done");
	endtask

	task automatic t_unmapped();
		logic [31:0] d;
		logic e;
		apb(1'b1, 8'h10, 32'h000000FF, d, e);
		`CHECK_EQ(e, 1'b1)
		apb(1'b0, 8'h10, 32'h00000000, d, e);
		`CHECK_EQ(d, 32'h00000000)
		$display("test unmapped done");
	endtask

	task automatic t_sources();
		logic [7:0] codes [4] = '{8'h02, 8'h03, 8'h23, 8'h00};
		int gaps [4] = '{24, 12, 18, 6};
		int n;
		logic tg;
		wr(A_PRESC, 8'h02);
		for (int i = 0; i < 4; i++) begin
			ctrl_set(codes[i]);
			tick_gap(n, tg);
			`CHECK_EQ(n, 6)
			`CHECK_EQ(fast_osc_run, 1'b1)
			ctrl_set(codes[i] | 8'h10);
			tick_gap(n, tg);
			`CHECK_EQ(n, gaps[i])
			`CHECK_EQ(tg, 1'b1)
			`CHECK_EQ(fast_osc_run, (i == 3) ? 1'b1 : 1'b0)
			ctrl_set(codes[i]);
		end
		$display("test sources done");
	endtask

	task automatic t_fail();
		int n;
		logic tg;
		wr(A_MASK, 8'h01);
		ctrl_set(8'h03);
		ctrl_set(8'h13);
		ext_a_stop <= 1'b1;
		repeat (150) @(posedge pclk);
		rd_chk(A_STAT, 32'h00000000);
		ext_a_stop <= 1'b0;
		ctrl_set(8'h1B);
		repeat (20) @(posedge pclk);
		ext_a_stop <= 1'b1;
		n = 0;
		while (fail_irq !== 1'b1 && n < 300) begin
			@(posedge pclk);
			n++;
		end
		`CHECK_EQ(n >= 64 && n <= 90, 1'b1)
		rd_chk(A_STAT, 32'h00000001);
		rd_chk(A_CTRL, 32'h0000000B);
		tick_gap(n, tg);
		`CHECK_EQ(n, 6)
		wr(A_STAT, 8'h01);
		rd_chk(A_STAT, 32'h00000000);
		wr(A_MASK, 8'h00);
		ext_a_stop <= 1'b0;
		ctrl_set(8'h1B);
		repeat (20) @(posedge pclk);
		ext_a_stop <= 1'b1;
		repeat (120) @(posedge pclk);
		`CHECK_EQ(fail_irq, 1'b0)
		wr(A_MASK, 8'h01);
		@(posedge pclk);
		`CHECK_EQ(fail_irq, 1'b1)
		irq_vector_ack <= 1'b1;
		@(posedge pclk);
		irq_vector_ack <= 1'b0;
		@(posedge pclk);
		`CHECK_EQ(fail_irq, 1'b0)
		$display("test failure done");
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// Free-running system clock at 10 MHz.
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end

	// Main sequence: reset for three cycles, then every scenario in turn.
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h00000000;
		irq_vector_ack = 1'b0;
		ext_a_stop = 1'b0;
		ext_b_stop = 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		t_reset_lock();
		t_unmapped();
		t_sources();
		t_fail();
		conclude();
	end

	// Watchdog well beyond the roughly one thousand cycles the scenarios need.
	initial begin
		repeat (20000) @(posedge pclk);
		num_errors++;
		conclude();
	end
endmodule

`default_nettype wire
